// [design/scd_params.svh]
// Constants for the strap configuration decoder: bus offsets, strap bit
// positions, register field positions and timing counts.
// Assumes inclusion by the package and the decoder module only.
`ifndef SCD_PARAMS_SVH
`define SCD_PARAMS_SVH

// ***************************************************************
// Register byte offsets (word aligned)
// ***************************************************************
`define SCD_OFS_STATUS    8'h00
`define SCD_OFS_STRAP     8'h04
`define SCD_OFS_LEDFUNC   8'h08
`define SCD_OFS_LEDCTRL   8'h0c
`define SCD_OFS_LINKCFG   8'h10
`define SCD_OFS_PORTADDR  8'h14

// ***************************************************************
// Strap vector layout: pin n occupies bits 4n+3..4n
// ***************************************************************
`define SCD_PINS          8
`define SCD_PIN_W         4
`define SCD_STRAP_W       32
`define SCD_SB_FN         0
`define SCD_SB_STAT       2
`define SCD_SB_ADDR       3
`define SCD_SB_MED0       15
`define SCD_SB_COMBINE    16
`define SCD_SB_FLIP       17
`define SCD_SB_SDPOL      18
`define SCD_SB_MED1       19
`define SCD_SB_CLKEN      20
`define SCD_SB_CLKFAST    21
`define SCD_SB_MED2       23
`define SCD_SB_DOWNSHIFT  30

// ***************************************************************
// Register field positions
// ***************************************************************
`define SCD_ST_DONE       0
`define SCD_ST_MEDRSV     1
`define SCD_LC_COPPER     15
`define SCD_LC_STAT_LO    0
`define SCD_LK_CLKEN      0
`define SCD_LK_CLKFAST    1
`define SCD_LK_SDPOL      2
`define SCD_LK_DOWNSHIFT  3
`define SCD_LK_MED_LO     4
`define SCD_PA_HIGH_LO    0
`define SCD_PA_FLIP       4
`define SCD_MED_RESERVED  3'h4
`define SCD_PORTS         4

// ***************************************************************
// Timing
// ***************************************************************
`define SCD_SETTLE_CYC    4'h8

`endif

// [design/scd_pkg.sv]
// Types for the strap configuration decoder.
// Assumes scd_params.svh sits in the include path.
`include "scd_params.svh"

package scd_pkg;

    // ***********************************************************
    // Capture sequence
    // ***********************************************************
    typedef enum logic {
        SCD_WAIT,
        SCD_RUN
    } scd_phase_e;

    // ***********************************************************
    // Whole state of the decoder
    // ***********************************************************
    typedef struct packed {
        scd_phase_e                  phase;
        logic [`SCD_STRAP_W-1:0]     sync1;
        logic [`SCD_STRAP_W-1:0]     sync2;
        logic [`SCD_STRAP_W-1:0]     sync3;
        logic [3:0]                  settleCnt;
        logic [`SCD_STRAP_W-1:0]     strapRaw;
        logic                        strapDone;
        logic [15:0]                 ledFunc;
        logic                        ledCopperOnly;
        logic [3:0]                  ledStatic;
        logic                        clkOutEn;
        logic                        clkOutFast;
        logic                        sigDetActLow;
        logic                        downshiftEn;
        logic [2:0]                  mediaSel;
        logic [2:0]                  addrHigh;
        logic                        addrFlip;
        logic [`SCD_PORTS-1:0][4:0]  portAddr;
        logic                        wrPend;
        logic [7:0]                  wrAddr;
        logic [31:0]                 rdata;
        logic                        readyOut;
        logic                        respOut;
    } scd_state_s;

endpackage

// [design/scd_strap_decoder.sv]
// Strap configuration decoder: samples eight strap codes after reset,
// turns them into power-up defaults and exposes them over AHB-Lite.
// Assumes strap codes arrive already digitised from the resistor sense
// front end, asynchronous to ref_clk, and one AHB-Lite master.
//
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module scd_strap_decoder
    import scd_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  strapCode0,
    input  wire logic [3:0]  strapCode1,
    input  wire logic [3:0]  strapCode2,
    input  wire logic [3:0]  strapCode3,
    input  wire logic [3:0]  strapCode4,
    input  wire logic [3:0]  strapCode5,
    input  wire logic [3:0]  strapCode6,
    input  wire logic [3:0]  strapCode7,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             strapDone,
    output logic [15:0]      indicatorFunc,
    output logic             indicatorCopperOnly,
    output logic [3:0]       indicatorStatic,
    output logic             recoveredClockOutEn,
    output logic             recoveredClockOutFast,
    output logic             signalDetectActLow,
    output logic             downshiftEn,
    output logic [2:0]       mediaSel,
    output logic [2:0]       portAddressHighBits,
    output logic             addressOrderFlip,
    output logic [4:0]       portAddr0,
    output logic [4:0]       portAddr1,
    output logic [4:0]       portAddr2,
    output logic [4:0]       portAddr3
);

    // ***********************************************************
    // Helpers
    // ***********************************************************
    // Port i answers at the strapped high bits plus i, or 3-i
    function automatic logic [4:0] portAddrOf(
        input logic [2:0] high,
        input logic       flip,
        input int         idx
    );
        logic [1:0] low;
        low = flip ? 2'(`SCD_PORTS - 1 - idx) : 2'(idx);
        return {high, low};
    endfunction

    // One bit of one pin's code out of the full strap vector; the function,
    // static and address high bit defaults go through here, the other strapped
    // defaults index the vector directly through the bit positions
    function automatic logic pinBit(
        input logic [`SCD_STRAP_W-1:0] vec,
        input int                      pin,
        input int                      pos
    );
        return vec[`SCD_PIN_W*pin + pos];
    endfunction

    // A transfer in its address phase that targets this slave
    function automatic logic busReq(
        input logic       sel,
        input logic       rdy,
        input logic [1:0] trans
    );
        return sel && rdy && trans[1];
    endfunction

    // ***********************************************************
    // State
    // ***********************************************************
    scd_state_s          state_r;
    scd_state_s          state_nxt;
    logic [`SCD_STRAP_W-1:0] pinVec;
    logic [7:0]          addrLow;

    // each pin's code keeps the rail bit on top
    assign pinVec = {strapCode7, strapCode6, strapCode5, strapCode4,
                     strapCode3, strapCode2, strapCode1, strapCode0};
    assign addrLow = haddr[7:0];

    // ***********************************************************
    // Next state
    // ***********************************************************
    always_comb begin
        state_nxt = state_r;

        // Three stages; only the second and third are compared
        state_nxt.sync1 = pinVec;
        state_nxt.sync2 = state_r.sync1;
        state_nxt.sync3 = state_r.sync2;
        state_nxt.readyOut = 1'b1;
        state_nxt.respOut = 1'b0;

        // Data phase of a write: software overrides the defaults
        if (state_r.wrPend) begin
            case (state_r.wrAddr)
                `SCD_OFS_LEDFUNC: begin
                    state_nxt.ledFunc = hwdata[15:0];
                end
                `SCD_OFS_LEDCTRL: begin
                    state_nxt.ledCopperOnly =
                        hwdata[`SCD_LC_COPPER];
                    state_nxt.ledStatic =
                        hwdata[`SCD_LC_STAT_LO +: 4];
                end
                `SCD_OFS_LINKCFG: begin
                    state_nxt.clkOutEn = hwdata[`SCD_LK_CLKEN];
                    state_nxt.clkOutFast = hwdata[`SCD_LK_CLKFAST];
                    state_nxt.sigDetActLow = hwdata[`SCD_LK_SDPOL];
                    state_nxt.downshiftEn = hwdata[`SCD_LK_DOWNSHIFT];
                    state_nxt.mediaSel =
                        hwdata[`SCD_LK_MED_LO +: 3];
                end
                // Address straps have no register substitute
                default: begin
                end
            endcase
        end

        state_nxt.wrPend = busReq(hsel, hready, htrans) && hwrite;
        if (state_nxt.wrPend) begin
            state_nxt.wrAddr = addrLow;
        end

        case (state_r.phase)
            SCD_WAIT: begin
                if (state_r.settleCnt != `SCD_SETTLE_CYC) begin
                    state_nxt.settleCnt = state_r.settleCnt + 4'h1;
                end else if (state_r.sync2 == state_r.sync3) begin
                    // One capture per reset; the load wins over a
                    // write landing in the same cycle
                    state_nxt.phase = SCD_RUN;
                    state_nxt.strapDone = 1'b1;
                    state_nxt.strapRaw = state_r.sync3;
                    // Function fields are four bits wide; the straps
                    // only reach the low two, software the rest
                    for (int i = 0; i < `SCD_PORTS; i++) begin
                        state_nxt.ledFunc[4*i +: 4] = {
                            2'h0,
                            pinBit(state_r.sync3, i, `SCD_SB_FN + 1),
                            pinBit(state_r.sync3, i, `SCD_SB_FN)
                        };
                        // 0 blinks, 1 holds static status
                        state_nxt.ledStatic[i] =
                            pinBit(state_r.sync3, i,
                                   `SCD_SB_STAT);
                    end
                    // Only the top three address bits are strapped;
                    // the low two come from the port index
                    state_nxt.addrHigh = {
                        pinBit(state_r.sync3, 2, `SCD_SB_ADDR),
                        pinBit(state_r.sync3, 1, `SCD_SB_ADDR),
                        pinBit(state_r.sync3, 0, `SCD_SB_ADDR)
                    };
                    state_nxt.addrFlip =
                        state_r.sync3[`SCD_SB_FLIP];
                    state_nxt.ledCopperOnly =
                        state_r.sync3[`SCD_SB_COMBINE];
                    state_nxt.sigDetActLow =
                        state_r.sync3[`SCD_SB_SDPOL];
                    state_nxt.clkOutEn =
                        state_r.sync3[`SCD_SB_CLKEN];
                    state_nxt.clkOutFast =
                        state_r.sync3[`SCD_SB_CLKFAST];
                    state_nxt.downshiftEn =
                        state_r.sync3[`SCD_SB_DOWNSHIFT];
                    state_nxt.mediaSel = {
                        state_r.sync3[`SCD_SB_MED2],
                        state_r.sync3[`SCD_SB_MED1],
                        state_r.sync3[`SCD_SB_MED0]
                    };
                end
            end
            SCD_RUN: begin
            end
            default: begin
                state_nxt.phase = SCD_WAIT;
            end
        endcase

        for (int i = 0; i < `SCD_PORTS; i++) begin
            state_nxt.portAddr[i] = portAddrOf(state_nxt.addrHigh,
                state_nxt.addrFlip, i);
        end

        // Read data is built from the next values, so a read right
        // after a write already sees the new contents
        if (busReq(hsel, hready, htrans) && !hwrite) begin
            state_nxt.rdata = 32'h0;
            case (addrLow)
                `SCD_OFS_STATUS: begin
                    state_nxt.rdata[`SCD_ST_DONE] = state_nxt.strapDone;
                    state_nxt.rdata[`SCD_ST_MEDRSV] =
                        (state_nxt.mediaSel == `SCD_MED_RESERVED);
                end
                `SCD_OFS_STRAP: begin
                    state_nxt.rdata = state_nxt.strapRaw;
                end
                `SCD_OFS_LEDFUNC: begin
                    state_nxt.rdata[15:0] = state_nxt.ledFunc;
                end
                `SCD_OFS_LEDCTRL: begin
                    state_nxt.rdata[`SCD_LC_COPPER] =
                        state_nxt.ledCopperOnly;
                    state_nxt.rdata[`SCD_LC_STAT_LO +: 4] =
                        state_nxt.ledStatic;
                end
                `SCD_OFS_LINKCFG: begin
                    state_nxt.rdata[`SCD_LK_CLKEN] = state_nxt.clkOutEn;
                    state_nxt.rdata[`SCD_LK_CLKFAST] =
                        state_nxt.clkOutFast;
                    state_nxt.rdata[`SCD_LK_SDPOL] =
                        state_nxt.sigDetActLow;
                    state_nxt.rdata[`SCD_LK_DOWNSHIFT] =
                        state_nxt.downshiftEn;
                    state_nxt.rdata[`SCD_LK_MED_LO +: 3] =
                        state_nxt.mediaSel;
                end
                `SCD_OFS_PORTADDR: begin
                    state_nxt.rdata[`SCD_PA_HIGH_LO +: 3] =
                        state_nxt.addrHigh;
                    state_nxt.rdata[`SCD_PA_FLIP] = state_nxt.addrFlip;
                end
                // Unmapped offsets read as zero
                default: begin
                end
            endcase
        end
    end

    // ***********************************************************
    // Register
    // ***********************************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ***********************************************************
    // Outputs
    // ***********************************************************
    assign hrdata                = state_r.rdata;
    assign hreadyout             = state_r.readyOut;
    assign hresp                 = state_r.respOut;
    assign strapDone             = state_r.strapDone;
    assign indicatorFunc         = state_r.ledFunc;
    assign indicatorCopperOnly   = state_r.ledCopperOnly;
    assign indicatorStatic       = state_r.ledStatic;
    assign recoveredClockOutEn   = state_r.clkOutEn;
    assign recoveredClockOutFast = state_r.clkOutFast;
    assign signalDetectActLow    = state_r.sigDetActLow;
    assign downshiftEn           = state_r.downshiftEn;
    assign mediaSel              = state_r.mediaSel;
    assign portAddressHighBits   = state_r.addrHigh;
    assign addressOrderFlip      = state_r.addrFlip;
    assign portAddr0             = state_r.portAddr[0];
    assign portAddr1             = state_r.portAddr[1];
    assign portAddr2             = state_r.portAddr[2];
    assign portAddr3             = state_r.portAddr[3];

endmodule // scd_strap_decoder

`default_nettype wire

// [tb/scd_strap_board.sv]
// Board strapping model: one rail tie and one resistor choice per pin.
// Assumes the bench picks the ties and holds them through capture.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Strap resistors seen as digitised codes
// ****************************************
module scd_strap_board (
    input  wire logic [7:0]  railSel,
    input  wire logic [23:0] resSel,
    output logic [3:0]       strapCode0,
    output logic [3:0]       strapCode1,
    output logic [3:0]       strapCode2,
    output logic [3:0]       strapCode3,
    output logic [3:0]       strapCode4,
    output logic [3:0]       strapCode5,
    output logic [3:0]       strapCode6,
    output logic [3:0]       strapCode7
);
    // Rail tie is the top bit, resistor index the low three
    assign strapCode0 = {railSel[0], resSel[2:0]};
    assign strapCode1 = {railSel[1], resSel[5:3]};
    assign strapCode2 = {railSel[2], resSel[8:6]};
    assign strapCode3 = {railSel[3], resSel[11:9]};
    assign strapCode4 = {railSel[4], resSel[14:12]};
    assign strapCode5 = {railSel[5], resSel[17:15]};
    assign strapCode6 = {railSel[6], resSel[20:18]};
    // All zero ties model a board that programs registers instead
    assign strapCode7 = {railSel[7], resSel[23:21]};
endmodule // scd_strap_board

`default_nettype wire

// [tb/scd_strap_decoder_properties.sv]
// Checker for the strap decoder, bound to its top module.
// Assumes straps stay steady from reset through capture.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Port level properties
// ****************************************
module scd_strap_decoder_chk (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [3:0]  strapCode0,
    input wire logic [3:0]  strapCode1,
    input wire logic [3:0]  strapCode2,
    input wire logic [3:0]  strapCode3,
    input wire logic [3:0]  strapCode4,
    input wire logic [3:0]  strapCode5,
    input wire logic [3:0]  strapCode7,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        strapDone,
    input wire logic [15:0] indicatorFunc,
    input wire logic        indicatorCopperOnly,
    input wire logic [3:0]  indicatorStatic,
    input wire logic        recoveredClockOutEn,
    input wire logic        recoveredClockOutFast,
    input wire logic        signalDetectActLow,
    input wire logic        downshiftEn,
    input wire logic [2:0]  mediaSel,
    input wire logic [2:0]  portAddressHighBits,
    input wire logic        addressOrderFlip,
    input wire logic [4:0]  portAddr0,
    input wire logic [4:0]  portAddr3
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_ready_high: assert property ($past(rst_n) |-> hreadyout)
        else $error("bus stalled");
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("error response");
    chk_done_hold: assert property (strapDone |=> strapDone)
        else $error("capture flag dropped");
    chk_capture_soon: assert property ($rose(rst_n) |-> ##[1:16] strapDone)
        else $error("no capture");
    chk_led_func: assert property ($rose(strapDone) |-> indicatorFunc ==
        {2'h0, strapCode3[1:0], 2'h0, strapCode2[1:0],
         2'h0, strapCode1[1:0], 2'h0, strapCode0[1:0]})
        else $error("indicator function default");
    chk_led_mode: assert property ($rose(strapDone) |->
        indicatorCopperOnly == strapCode4[0] && indicatorStatic ==
        {strapCode3[2], strapCode2[2], strapCode1[2], strapCode0[2]})
        else $error("indicator mode default");
    chk_link_dflt: assert property ($rose(strapDone) |->
        recoveredClockOutEn == strapCode5[0] && downshiftEn == strapCode7[2]
        && recoveredClockOutFast == strapCode5[1]
        && signalDetectActLow == strapCode4[2]
        && mediaSel == {strapCode5[3], strapCode4[3], strapCode3[3]})
        else $error("link default");
    chk_addr_dflt: assert property ($rose(strapDone) |->
        portAddressHighBits == {strapCode2[3], strapCode1[3], strapCode0[3]}
        && addressOrderFlip == strapCode4[1])
        else $error("address default");
    chk_port_map: assert property (strapDone |->
        portAddr0 == {portAddressHighBits, addressOrderFlip ? 2'h3 : 2'h0}
        && portAddr3 == {portAddressHighBits, addressOrderFlip ? 2'h0 : 2'h3})
        else $error("port address order");
    chk_addr_fixed: assert property (strapDone |=>
        $stable(portAddressHighBits) && $stable(addressOrderFlip))
        else $error("address bits moved");
endmodule // scd_strap_decoder_chk

bind scd_strap_decoder scd_strap_decoder_chk i_chk (
    .ref_clk, .rst_n, .strapCode0, .strapCode1, .strapCode2, .strapCode3,
    .strapCode4, .strapCode5, .strapCode7, .hreadyout, .hresp, .strapDone,
    .indicatorFunc, .indicatorCopperOnly, .indicatorStatic,
    .recoveredClockOutEn, .recoveredClockOutFast, .signalDetectActLow,
    .downshiftEn, .mediaSel, .portAddressHighBits, .addressOrderFlip,
    .portAddr0, .portAddr3);

`default_nettype wire

// [tb/tb.sv]
// Self-checking bench: strap tables, register overrides over AHB-Lite.
// Assumes one bus master and the board model on the strap pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin mismatches++; \
    $display("BAD %0t got %h exp %h", $time, a, b); end end

module tb;
    import scd_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0] railSel = 8'h00;
    logic [23:0] resSel = 24'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
    logic [1:0] htrans = 2'h0;
    logic [3:0] sc0, sc1, sc2, sc3, sc4, sc5, sc6, sc7, indicatorStatic;
    logic hreadyout, hresp, strapDone, indicatorCopperOnly, addressOrderFlip;
    logic clkEn, clkFast, sdLow, downshiftEn;
    logic [15:0] indicatorFunc;
    logic [2:0] mediaSel, portAddressHighBits;
    logic [4:0] pa0, pa1, pa2, pa3;
    int mismatches = 0, cmpCount = 0;
    // Last entry leaves pin 4 flip set so the lock-in check sees a one
    logic [31:0] cfgTab [4] = '{32'h0, 32'h40b7_5d5d, 32'h0038_a2a2,
                                32'h402b_ffff};

    always #20 ref_clk = ~ref_clk;

    scd_strap_board i_board (.railSel(railSel), .resSel(resSel),
        .strapCode0(sc0), .strapCode1(sc1), .strapCode2(sc2), .strapCode3(sc3),
        .strapCode4(sc4), .strapCode5(sc5), .strapCode6(sc6), .strapCode7(sc7));

    scd_strap_decoder i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .strapCode0(sc0), .strapCode1(sc1), .strapCode2(sc2), .strapCode3(sc3),
        .strapCode4(sc4), .strapCode5(sc5), .strapCode6(sc6), .strapCode7(sc7),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .strapDone(strapDone),
        .indicatorFunc(indicatorFunc), .indicatorCopperOnly(indicatorCopperOnly),
        .indicatorStatic(indicatorStatic), .recoveredClockOutEn(clkEn),
        .recoveredClockOutFast(clkFast), .signalDetectActLow(sdLow),
        .downshiftEn(downshiftEn), .mediaSel(mediaSel),
        .portAddressHighBits(portAddressHighBits),
        .addressOrderFlip(addressOrderFlip), .portAddr0(pa0), .portAddr1(pa1),
        .portAddr2(pa2), .portAddr3(pa3));

    // ****************************************
    // Bus and check tasks
    // ****************************************
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= w ? d : 32'h0;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        q = hrdata;
    endtask

    task automatic check_cfg(input logic [31:0] s);
        logic [2:0] hi;
        hi = {s[11], s[7], s[3]};
        `CHK(indicatorFunc, {2'h0, s[13:12], 2'h0, s[9:8], 2'h0, s[5:4], 2'h0, s[1:0]})
        `CHK(indicatorStatic, {s[14], s[10], s[6], s[2]})
        `CHK(indicatorCopperOnly, s[16])
        `CHK({clkFast, clkEn}, s[21:20])
        `CHK(sdLow, s[18])
        `CHK(downshiftEn, s[30])
        `CHK(mediaSel, {s[23], s[19], s[15]})
        `CHK(portAddressHighBits, hi)
        `CHK({pa0, pa1}, {hi, s[17] ? 2'h3 : 2'h0, hi, s[17] ? 2'h2 : 2'h1})
        `CHK({pa2, pa3}, {hi, s[17] ? 2'h1 : 2'h2, hi, s[17] ? 2'h0 : 2'h3})
        ahb(1'b0, 8'h04, 32'h0, rdv);
        `CHK(rdv, s)
        ahb(1'b0, 8'h00, 32'h0, rdv);
        `CHK(rdv, {30'h0, {s[23], s[19], s[15]} == 3'h4, 1'b1})
    endtask

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", cmpCount, mismatches);
        if (mismatches == 0 && cmpCount > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        for (int k = 0; k < 4; k++) begin
            @(posedge ref_clk);
            rst_n <= 1'b0;
            for (int n = 0; n < 8; n++) begin
                railSel[n] <= cfgTab[k][4*n+3];
                resSel[3*n +: 3] <= cfgTab[k][4*n +: 3];
            end
            repeat (10) @(posedge ref_clk);
            rst_n <= 1'b1;
            repeat (40) if (strapDone !== 1'b1) @(posedge ref_clk);
            `CHK(strapDone, 1'b1)
            check_cfg(cfgTab[k]);
        end
        ahb(1'b1, 8'h08, 32'h0000_3210, rdv);
        ahb(1'b0, 8'h08, 32'h0, rdv);
        `CHK(rdv, 32'h0000_3210)
        `CHK(indicatorFunc, 16'h3210)
        ahb(1'b1, 8'h0c, 32'h0000_800a, rdv);
        ahb(1'b0, 8'h0c, 32'h0, rdv);
        `CHK({indicatorCopperOnly, indicatorStatic}, 5'h1a)
        ahb(1'b1, 8'h10, 32'h0000_004f, rdv);
        ahb(1'b0, 8'h00, 32'h0, rdv);
        `CHK(rdv, 32'h3)
        `CHK({mediaSel, downshiftEn, sdLow, clkFast, clkEn}, 7'h4f)
        // Address straps have no register behind them
        ahb(1'b1, 8'h14, 32'h0, rdv);
        ahb(1'b0, 8'h14, 32'h0, rdv);
        `CHK(rdv, 32'h17)
        ahb(1'b0, 8'h20, 32'h0, rdv);
        `CHK(rdv, 32'h0)
        railSel <= 8'h00;
        resSel <= 24'h0;
        repeat (20) @(posedge ref_clk);
        ahb(1'b0, 8'h04, 32'h0, rdv);
        `CHK(rdv, cfgTab[3])
        `CHK(pa0, 5'h1f)
        end_sim;
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        mismatches++;
        end_sim;
    end
endmodule // tb

`default_nettype wire
